/* rtl/pllcr_pkg.sv */
// Register map, field positions, reset values and timing counts of the PLL control bank.
// Assumes a byte-wide register port addressed by the printed register offsets.
package pllcr_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] PLLCR_ADDR_CTRL_A     = 8'h38;
  localparam logic [7:0] PLLCR_ADDR_CTRL_B     = 8'h39;
  localparam logic [7:0] PLLCR_ADDR_NDIV_HIGH  = 8'h3a;
  localparam logic [7:0] PLLCR_ADDR_NDIV_LOW   = 8'h3b;
  localparam logic [7:0] PLLCR_ADDR_NUM_TOP    = 8'h3c;
  localparam logic [7:0] PLLCR_ADDR_NUM_MID    = 8'h3d;
  localparam logic [7:0] PLLCR_ADDR_NUM_LOW    = 8'h3e;
  localparam logic [7:0] PLLCR_ADDR_STATUS     = 8'h3f;

  // ==========================================================================
  // Field positions
  localparam int PLLCR_BIT_POWER_DOWN = 0;
  localparam int PLLCR_BIT_RESYNC_EN  = 1;
  localparam int PLLCR_BIT_DOUBLER    = 4;
  localparam int PLLCR_BIT_RSVD_B5    = 5;
  localparam int PLLCR_BIT_CAL_DONE   = 0;
  localparam int PLLCR_BIT_PLL_ON     = 1;
  localparam int PLLCR_BIT_CAL_BUSY   = 2;

  // ==========================================================================
  // Widths and masks of writable bits
  localparam int         PLLCR_NDIV_W   = 12;
  localparam int         PLLCR_NUM_W    = 22;
  localparam logic [7:0] PLLCR_MASK_A   = 8'h03;
  localparam logic [7:0] PLLCR_MASK_B   = 8'h3f;
  localparam logic [7:0] PLLCR_MASK_NIB = 8'h0f;
  localparam logic [7:0] PLLCR_MASK_TOP = 8'h3f;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] PLLCR_RST_CTRL_A    = 8'h02;
  localparam logic [7:0] PLLCR_RST_CTRL_B    = 8'h18;
  localparam logic [7:0] PLLCR_RST_NDIV_HIGH = 8'h00;
  localparam logic [7:0] PLLCR_RST_NDIV_LOW  = 8'h66;
  localparam logic [7:0] PLLCR_RST_NUM       = 8'h00;

  // ==========================================================================
  // Charge pump codes
  localparam logic [3:0] PLLCR_CP_MAX_STEP = 4'h7;
  localparam logic [3:0] PLLCR_CP_HIGH     = 4'h8;

  // ==========================================================================
  // Calibration timing
  localparam int PLLCR_CLK_MHZ       = 200;
  localparam int PLLCR_CAL_TIME_US   = 10;
  localparam int PLLCR_CAL_CYCLES    = PLLCR_CAL_TIME_US * PLLCR_CLK_MHZ;
  localparam int PLLCR_CAL_CNT_W     = 16;

  typedef enum logic [1:0] {PLLCR_CAL_OFF, PLLCR_CAL_RUN, PLLCR_CAL_LOCKED} pllcr_cal_state_t;

endpackage : pllcr_pkg

/* rtl/pllcr_calseq.sv */
// Calibration sequencer: holds the PLL off while powered down and runs a timed calibration on release.
// Assumes power_down comes from a register on the same clock.
module pllcr_calseq
  import pllcr_pkg::*;
#(
  parameter int CAL_CYCLES = PLLCR_CAL_CYCLES
)
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Control
  input  wire logic power_down,
  // State
  output logic      pll_enable,
  output logic      cal_reset,
  output logic      cal_busy,
  output logic      cal_done
);

  pllcr_cal_state_t             state_r;
  pllcr_cal_state_t             state_nxt;
  logic [PLLCR_CAL_CNT_W-1:0]   cnt_r;
  logic [PLLCR_CAL_CNT_W-1:0]   cnt_nxt;
  localparam logic [PLLCR_CAL_CNT_W-1:0] CAL_LAST = PLLCR_CAL_CNT_W'(CAL_CYCLES - 1);

  // ==========================================================================
  // Sequencing
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      PLLCR_CAL_OFF:
      begin
        cnt_nxt = '0;
        if (!power_down)
          state_nxt = PLLCR_CAL_RUN;
      end
      PLLCR_CAL_RUN:
      begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CAL_LAST)
          state_nxt = PLLCR_CAL_LOCKED;
      end
      PLLCR_CAL_LOCKED: ;
    endcase
    if (power_down)
      state_nxt = PLLCR_CAL_OFF;
  end

  // Reset lands in the off state so calibration starts one cycle later, as after power-up.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state_r <= PLLCR_CAL_OFF;
      cnt_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign pll_enable = (state_r != PLLCR_CAL_OFF);
  assign cal_reset  = (state_r == PLLCR_CAL_OFF);
  assign cal_busy   = (state_r == PLLCR_CAL_RUN);
  assign cal_done   = (state_r == PLLCR_CAL_LOCKED);

endmodule : pllcr_calseq

/* rtl/pllcr_sync.sv */
// Per-channel resync request generator for outputs sourced by the PLL.
// Assumes sync_event is already synchronised to ref_clk.
module pllcr_sync
#(
  parameter int NUM_CH = 8
)
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // Control
  input  wire logic              resync_en,
  input  wire logic              sync_event,
  input  wire logic [NUM_CH-1:0] ch_uses_pll,
  // Per-channel pulse
  output logic      [NUM_CH-1:0] ch_resync
);

  logic [NUM_CH-1:0] pulse_r;

  // ==========================================================================
  // One flop per channel
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    always_ff @(posedge ref_clk)
    begin
      if (!nrst)
        pulse_r[i] <= 1'b0;
      else
        pulse_r[i] <= sync_event & resync_en & ch_uses_pll[i];
    end
  end

  assign ch_resync = pulse_r;

endmodule : pllcr_sync

/* rtl/pllcr_top.sv */
// PLL control register bank: byte registers steering the PLL, its calibration and output resync.
// Assumes a same-clock register port with one-cycle strobes; sync_in is an asynchronous pin.
//
// What this block does
// - Resync enable resyncs PLL-sourced channels; resets 1.
// - Power-down resets 0; PLL calibrates after reset.
// - Power-down set disables PLL, resets calibration.
// - Power-down cleared re-enables PLL, recalibrates automatically.
// - Bit 4 enables primary doubler; resets 1.
// - Four-bit charge pump code; resets to 8.
// - Twelve-bit integer divider over two registers.
// - Divider codes 0 and 1 give ratio 1.
// - Divider resets to 0x066, ratio 102.
// - Numerator 22 bits; top and mid reset zero.
// - Numerator low byte in third register, resets zero.
module pllcr_top
  import pllcr_pkg::*;
#(
  parameter int NUM_CH     = 8,
  parameter int CAL_CYCLES = PLLCR_CAL_CYCLES
)
(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  // Register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  // Output channel sync
  input  wire logic                    sync_in,
  input  wire logic [NUM_CH-1:0]       ch_uses_pll,
  output logic      [NUM_CH-1:0]       ch_resync,
  // Analog PLL controls
  output logic                         pll_enable,
  output logic                         cal_reset,
  output logic                         primary_ref_doubler_enable,
  output logic      [3:0]              charge_pump_gain,
  output logic      [PLLCR_NDIV_W-1:0] integer_feedback_divider,
  output logic      [PLLCR_NUM_W-1:0]  frac_numerator
);

  // ==========================================================================
  // Registers
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [7:0] ndiv_high_r;
  logic [7:0] ndiv_low_r;
  logic [7:0] num_top_r;
  logic [7:0] num_mid_r;
  logic [7:0] num_low_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       sync_meta_r;
  logic       sync_r;
  logic       sync_d_r;
  logic       pll_enable_r;
  logic       cal_reset_r;
  logic [3:0] cp_r;
  logic [PLLCR_NDIV_W-1:0] ndiv_ratio_r;

  // ==========================================================================
  // Decode
  wire        wr_a    = reg_wr && (reg_addr == PLLCR_ADDR_CTRL_A);
  wire        wr_b    = reg_wr && (reg_addr == PLLCR_ADDR_CTRL_B);
  wire        wr_nh   = reg_wr && (reg_addr == PLLCR_ADDR_NDIV_HIGH);
  wire        wr_nl   = reg_wr && (reg_addr == PLLCR_ADDR_NDIV_LOW);
  wire        wr_top  = reg_wr && (reg_addr == PLLCR_ADDR_NUM_TOP);
  wire        wr_mid  = reg_wr && (reg_addr == PLLCR_ADDR_NUM_MID);
  wire        wr_low  = reg_wr && (reg_addr == PLLCR_ADDR_NUM_LOW);

  wire        power_down = ctrl_a_r[PLLCR_BIT_POWER_DOWN];
  wire        resync_en  = ctrl_a_r[PLLCR_BIT_RESYNC_EN];
  wire        sync_event = sync_r & ~sync_d_r;
  wire        cal_en;
  wire        cal_rst;
  wire        cal_busy;
  wire        cal_done;
  wire [PLLCR_NDIV_W-1:0] ndiv_code = {ndiv_high_r[3:0], ndiv_low_r};
  wire [PLLCR_NDIV_W-1:0] ndiv_eff  = (ndiv_code <= PLLCR_NDIV_W'(1)) ?
                                      PLLCR_NDIV_W'(1) : ndiv_code;
  // Codes 0 and above 8 are undefined; they fall back to the reset current rather than reach the pump.
  wire        cp_code_legal = ((ctrl_b_r[3:0] <= PLLCR_CP_MAX_STEP) && (ctrl_b_r[3:0] != 4'h0))
                              || (ctrl_b_r[3:0] == PLLCR_CP_HIGH);
  wire [3:0]  cp_eff = (cp_code_legal) ? ctrl_b_r[3:0] : PLLCR_CP_HIGH;
  wire [7:0]  status = {5'h00, cal_busy, cal_en, cal_done};

  // ==========================================================================
  // Read mux; registers read back as stored, so reserved bit 5 of ctrl_b_r is not masked
  always_comb
  begin
    unique case (reg_addr)
      PLLCR_ADDR_CTRL_A:    rdata_nxt = ctrl_a_r;
      PLLCR_ADDR_CTRL_B:    rdata_nxt = ctrl_b_r;
      PLLCR_ADDR_NDIV_HIGH: rdata_nxt = ndiv_high_r;
      PLLCR_ADDR_NDIV_LOW:  rdata_nxt = ndiv_low_r;
      PLLCR_ADDR_NUM_TOP:   rdata_nxt = num_top_r;
      PLLCR_ADDR_NUM_MID:   rdata_nxt = num_mid_r;
      PLLCR_ADDR_NUM_LOW:   rdata_nxt = num_low_r;
      PLLCR_ADDR_STATUS:    rdata_nxt = status;
      default:              rdata_nxt = 8'h00;
    endcase
    if (!reg_rd)
      rdata_nxt = 8'h00;
  end

  // ==========================================================================
  // Register writes; only documented bits and reserved bit 5 of ctrl_b_r are stored
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ctrl_a_r    <= PLLCR_RST_CTRL_A;
      ctrl_b_r    <= PLLCR_RST_CTRL_B;
      ndiv_high_r <= PLLCR_RST_NDIV_HIGH;
      ndiv_low_r  <= PLLCR_RST_NDIV_LOW;
      num_top_r   <= PLLCR_RST_NUM;
      num_mid_r   <= PLLCR_RST_NUM;
      num_low_r   <= PLLCR_RST_NUM;
    end
    else
    begin
      if (wr_a)
        ctrl_a_r <= reg_wdata & PLLCR_MASK_A;
      if (wr_b)
        ctrl_b_r <= reg_wdata & PLLCR_MASK_B;
      if (wr_nh)
        ndiv_high_r <= reg_wdata & PLLCR_MASK_NIB;
      if (wr_nl)
        ndiv_low_r <= reg_wdata;
      if (wr_top)
        num_top_r <= reg_wdata & PLLCR_MASK_TOP;
      if (wr_mid)
        num_mid_r <= reg_wdata;
      if (wr_low)
        num_low_r <= reg_wdata;
    end
  end

  // ==========================================================================
  // Sync pin capture and read data
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      sync_meta_r <= 1'b0;
      sync_r      <= 1'b0;
      sync_d_r    <= 1'b0;
      rdata_r     <= 8'h00;
    end
    else
    begin
      sync_meta_r <= sync_in;
      sync_r      <= sync_meta_r;
      sync_d_r    <= sync_r;
      rdata_r     <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Registered analog controls, so every output comes from a flop
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pll_enable_r <= 1'b0;
      cal_reset_r  <= 1'b1;
      cp_r         <= PLLCR_CP_HIGH;
      ndiv_ratio_r <= {PLLCR_RST_NDIV_HIGH[3:0], PLLCR_RST_NDIV_LOW};
    end
    else
    begin
      pll_enable_r <= cal_en;
      cal_reset_r  <= cal_rst;
      cp_r         <= cp_eff;
      ndiv_ratio_r <= ndiv_eff;
    end
  end

  // ==========================================================================
  // Submodules
  pllcr_calseq #(
    .CAL_CYCLES (CAL_CYCLES)
  ) u_calseq (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .power_down (power_down),
    .pll_enable (cal_en),
    .cal_reset  (cal_rst),
    .cal_busy   (cal_busy),
    .cal_done   (cal_done)
  );

  pllcr_sync #(
    .NUM_CH (NUM_CH)
  ) u_sync (
    .ref_clk     (ref_clk),
    .nrst        (nrst),
    .resync_en   (resync_en),
    .sync_event  (sync_event),
    .ch_uses_pll (ch_uses_pll),
    .ch_resync   (ch_resync)
  );

  assign reg_rdata                  = rdata_r;
  assign pll_enable                 = pll_enable_r;
  assign cal_reset                  = cal_reset_r;
  assign primary_ref_doubler_enable = ctrl_b_r[PLLCR_BIT_DOUBLER];
  assign charge_pump_gain           = cp_r;
  assign integer_feedback_divider   = ndiv_ratio_r;
  assign frac_numerator             = {num_top_r[5:0], num_mid_r, num_low_r};

endmodule : pllcr_top

/* testbench/pllcr_checker.sv */
// Port assertions for the PLL control register bank.
// Assumes one clock domain with the synchronous active-low reset.
module pllcr_checker
  import pllcr_pkg::*;
#(
  parameter int NUM_CH = 8
)
(
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    nrst,
  // Register port
  input wire logic [7:0]              reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata,
  // Channel sync and PLL controls
  input wire logic [NUM_CH-1:0]       ch_uses_pll,
  input wire logic [NUM_CH-1:0]       ch_resync,
  input wire logic                    pll_enable,
  input wire logic                    cal_reset,
  input wire logic                    primary_ref_doubler_enable,
  input wire logic [3:0]              charge_pump_gain,
  input wire logic [PLLCR_NDIV_W-1:0] integer_feedback_divider,
  input wire logic [PLLCR_NUM_W-1:0]  frac_numerator
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // ==========================================
  // Sequences and properties
  sequence s_ctrl_a_wr;
    reg_wr && reg_addr == PLLCR_ADDR_CTRL_A;
  endsequence
  sequence s_pll_off;
    !pll_enable && cal_reset;
  endsequence
  property p_doubler;
    reg_wr && reg_addr == PLLCR_ADDR_CTRL_B
      |-> ##2 primary_ref_doubler_enable == $past(reg_wdata[PLLCR_BIT_DOUBLER], 2);
  endproperty
  property p_num_top;
    reg_wr && reg_addr == PLLCR_ADDR_NUM_TOP
      |-> ##2 frac_numerator[21:16] == $past(reg_wdata[5:0], 2);
  endproperty

  // ==========================================
  // Assertions
  chk_idle_read: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_pdn_off: assert property (s_ctrl_a_wr ##0 reg_wdata[0] |-> ##3 s_pll_off)
    else $error("pll not off after power down");
  chk_pdn_wake: assert property (s_ctrl_a_wr ##0 !reg_wdata[0] ##0 s_pll_off |-> ##3 (pll_enable && !cal_reset))
    else $error("pll not restarted after power down clear");
  chk_reset_start: assert property ($rose(nrst) |-> ##[1:2] pll_enable)
    else $error("pll not enabled after reset");
  chk_resync_gate: assert property (|ch_resync |-> (ch_resync & ~ch_uses_pll) == '0)
    else $error("resync on channel not using pll");
  chk_resync_pulse: assert property (|ch_resync |=> ch_resync == '0)
    else $error("resync longer than one cycle");
  chk_cp_legal: assert property (charge_pump_gain inside {[4'h1:4'h8]})
    else $error("charge pump code out of range");
  chk_div_nonzero: assert property (integer_feedback_divider != '0)
    else $error("divider ratio zero");
  chk_doubler_follow: assert property (p_doubler)
    else $error("doubler does not follow write");
  chk_num_top: assert property (p_num_top)
    else $error("numerator top does not follow write");
endmodule : pllcr_checker

bind pllcr_top pllcr_checker #(.NUM_CH(NUM_CH)) pllcr_checker_i (
  .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch_uses_pll(ch_uses_pll), .ch_resync(ch_resync),
  .pll_enable(pll_enable), .cal_reset(cal_reset), .primary_ref_doubler_enable(primary_ref_doubler_enable),
  .charge_pump_gain(charge_pump_gain), .integer_feedback_divider(integer_feedback_divider),
  .frac_numerator(frac_numerator));

/* testbench/testbench.sv */
// Self-checking bench for the PLL control register bank.
// Assumes the checker binds itself to the top module.
module testbench
  import pllcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short calibration keeps the run brief.
  localparam int CAL = 8;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sync_in = 1'b0;
  logic [7:0] ch_uses_pll = 8'ha5;
  logic [7:0] reg_rdata, ch_resync, seen;
  logic pll_enable, cal_reset, primary_ref_doubler_enable;
  logic [3:0] charge_pump_gain;
  logic [11:0] integer_feedback_divider;
  logic [21:0] frac_numerator;
  int errors = 0;
  int check_count = 0;
  logic [7:0] rst_val [7] = '{8'h02, 8'h18, 8'h00, 8'h66, 8'h00, 8'h00, 8'h00};
  logic [7:0] wr_mask [7] = '{8'h03, 8'h3f, 8'h0f, 8'hff, 8'h3f, 8'hff, 8'hff};
  logic [11:0] div_in [4] = '{12'h000, 12'h001, 12'h123, 12'hfff};
  logic [11:0] div_ex [4] = '{12'h001, 12'h001, 12'h123, 12'hfff};

  always #2.5 ref_clk = ~ref_clk;

  pllcr_top #(.NUM_CH(8), .CAL_CYCLES(CAL)) pllcr_top_i (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_in(sync_in), .ch_uses_pll(ch_uses_pll),
    .ch_resync(ch_resync), .pll_enable(pll_enable), .cal_reset(cal_reset),
    .primary_ref_doubler_enable(primary_ref_doubler_enable), .charge_pump_gain(charge_pump_gain),
    .integer_feedback_divider(integer_feedback_divider), .frac_numerator(frac_numerator));

  // ==========================================
  // Tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check($sformatf("reg %h", a), 32'(exp), 32'(reg_rdata));
  endtask : reg_read

  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : settle

  // Collects every resync pulse seen while the synchroniser works through one edge.
  task automatic sync_pulse(input logic [7:0] exp);
    seen = 8'h00;
    @(posedge ref_clk);
    sync_in <= 1'b1;
    repeat (10)
    begin
      @(posedge ref_clk);
      #1 seen = seen | ch_resync;
    end
    @(posedge ref_clk);
    sync_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    check("ch_resync", 32'(exp), 32'(seen));
  endtask : sync_pulse

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // ==========================================
  // Tests
  initial
  begin
    repeat (2) @(posedge ref_clk);
    #1 check("divider", 32'd102, 32'(integer_feedback_divider));
    check("pll_enable", 32'h0, 32'(pll_enable));
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 check("pll_enable", 32'h1, 32'(pll_enable));
    repeat (CAL + 4) @(posedge ref_clk);
    reg_read(PLLCR_ADDR_STATUS, 8'h03);
    for (int i = 0; i < 7; i++)
      reg_read(PLLCR_ADDR_CTRL_A + 8'(i), rst_val[i]);
    check("doubler", 32'h1, 32'(primary_ref_doubler_enable));
    check("cp", 32'h8, 32'(charge_pump_gain));
    check("divider", 32'd102, 32'(integer_feedback_divider));
    check("numerator", 32'h0, 32'(frac_numerator));
    $display("test reset done");
    for (int i = 0; i < 7; i++)
    begin
      reg_write(PLLCR_ADDR_CTRL_A + 8'(i), 8'hff);
      reg_read(PLLCR_ADDR_CTRL_A + 8'(i), wr_mask[i]);
    end
    settle();
    check("pll_enable", 32'h0, 32'(pll_enable));
    check("cal_reset", 32'h1, 32'(cal_reset));
    check("divider", 32'hfff, 32'(integer_feedback_divider));
    check("numerator", 32'h3fffff, 32'(frac_numerator));
    check("cp", 32'h8, 32'(charge_pump_gain));
    reg_write(8'h40, 8'h55);
    reg_read(8'h40, 8'h00);
    reg_read(PLLCR_ADDR_STATUS, 8'h00);
    reg_write(PLLCR_ADDR_CTRL_A, 8'h02);
    settle();
    check("pll_enable", 32'h1, 32'(pll_enable));
    check("cal_reset", 32'h0, 32'(cal_reset));
    repeat (CAL + 4) @(posedge ref_clk);
    reg_read(PLLCR_ADDR_STATUS, 8'h03);
    $display("test power down done");
    for (int c = 0; c < 9; c++)
    begin
      reg_write(PLLCR_ADDR_CTRL_B, 8'(c));
      settle();
      check("cp", (c == 0) ? 32'h8 : 32'(c), 32'(charge_pump_gain));
      check("doubler", 32'h0, 32'(primary_ref_doubler_enable));
    end
    for (int i = 0; i < 4; i++)
    begin
      reg_write(PLLCR_ADDR_NDIV_HIGH, {4'h0, div_in[i][11:8]});
      reg_write(PLLCR_ADDR_NDIV_LOW, div_in[i][7:0]);
      settle();
      check("divider", 32'(div_ex[i]), 32'(integer_feedback_divider));
    end
    reg_write(PLLCR_ADDR_NUM_TOP, 8'h15);
    reg_write(PLLCR_ADDR_NUM_MID, 8'ha5);
    reg_write(PLLCR_ADDR_NUM_LOW, 8'h5a);
    settle();
    check("numerator", 32'h15a55a, 32'(frac_numerator));
    $display("test fields done");
    sync_pulse(8'ha5);
    reg_write(PLLCR_ADDR_CTRL_A, 8'h00);
    sync_pulse(8'h00);
    reg_write(PLLCR_ADDR_CTRL_A, 8'h02);
    ch_uses_pll <= 8'h3c;
    sync_pulse(8'h3c);
    $display("test resync done");
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("Error watchdog expected end seen timeout");
    print_verdict();
  end
endmodule : testbench
